// ### dsrb_status_bank.sv
// read-only status and interrupt source register bank
`timescale 1ns/1ps
`default_nettype none
module dsrb_status_bank
  import dsrb_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  // control port, byte wide
  input  wire logic                    rd_i,
  input  wire logic                    wr_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wdata_i,
  output logic      [DATA_W-1:0]       rdata_o,
  output logic                         rvalid_o,
  // live status from the datapath
  input  wire logic [CHANNELS*8-1:0]   vol_level_i,
  input  wire logic [CHANNELS-1:0]     automute_active_i,
  input  wire logic [CHANNELS-1:0]     ramp_up_done_i,
  input  wire logic [CHANNELS-1:0]     ramp_down_done_i,
  input  wire logic [DOP_W-1:0]        dop_valid_i,
  input  wire logic                    spdif_valid_i,
  input  wire logic                    tdm_data_valid_i,
  input  wire logic                    bck_valid_i,
  input  wire logic                    ws_valid_i,
  input  wire logic                    asynchronous_lock_i,
  input  wire logic [2:0]              monitor_en_i,
  input  wire logic [1:0]              auto_source_choice_i,
  input  wire logic                    ratio_valid_i,
  input  wire logic [CHANNELS-1:0]     gpio_i,
  input  wire logic [COEFF_W-1:0]      coeff_i,
  // payload capture and host byte select
  input  wire logic                    payload_we_i,
  input  wire logic [PAYLOAD_AW-1:0]   payload_idx_i,
  input  wire logic [7:0]              payload_byte_i,
  input  wire logic [PAYLOAD_AW-1:0]   payload_sel_i,
  // live source word toward the interrupt latch
  output logic      [SRC_W-1:0]        src_flags_o
);
  // whole state of the bank except the payload store
  typedef struct packed {
    logic [CHANNELS-1:0] vol_min;     // volume zero per channel
    logic [CHANNELS-1:0] mute;        // automute per channel
    logic [CHANNELS-1:0] ramp_up;     // ramped up per channel
    logic [CHANNELS-1:0] ramp_dn;     // ramped down per channel
    logic [DOP_W-1:0]    dop;         // dop valid flags
    logic                spdif_ok;    // s/pdif valid
    logic                tdm_ok;      // tdm data valid
    logic                clkmon_ok;   // serial clock monitor flag
    logic [1:0]          auto_sel;    // auto source choice
    logic                ratio_ok;    // clock ratio valid
    logic [CHANNELS-1:0] gpio_meta;   // pin sync stage one
    logic [CHANNELS-1:0] gpio_sync;   // pin sync stage two
    logic [COEFF_W-1:0]  coeff;       // coefficient snapshot
    logic [DATA_W-1:0]   rdata;       // read data flop
    logic                rvalid;      // read answer pulse
    logic [SRC_W-1:0]    src;         // source word flop
  } dsrb_st_t;

  dsrb_st_t            st_reg;      // registered state
  dsrb_st_t            st_next;     // next state
  logic [CHANNELS-1:0] vol_zero;    // per-channel compare
  dsrb_mem_if          mif ();      // payload store port

  // one comparator per channel against the minimum volume code
  for (genvar c = 0; c < CHANNELS; c++) begin : g_volcmp
    assign vol_zero[c] = (vol_level_i[c*8 +: 8] == VOL_ZERO);
  end

  // payload bytes land in the store; the host select picks the read
  assign mif.wr_en   = payload_we_i;
  assign mif.wr_addr = payload_idx_i;
  assign mif.wr_data = payload_byte_i;
  assign mif.rd_addr = payload_sel_i;

  dsrb_payload_mem u_payload (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .port   (mif.mem)
  );

  // sample status, synchronise pins, answer reads
  always_comb begin
    st_next = st_reg;
    // flags are live: nothing here holds a flag once its cause is gone,
    // the sticky copies live in the latch block behind src_flags_o
    st_next.vol_min  = vol_zero;
    st_next.mute     = automute_active_i;
    st_next.ramp_up  = ramp_up_done_i;
    st_next.ramp_dn  = ramp_down_done_i;
    st_next.dop      = dop_valid_i;
    st_next.spdif_ok = spdif_valid_i;
    st_next.tdm_ok   = tdm_data_valid_i;
    // a monitor that is switched off does not spoil the flag
    st_next.clkmon_ok = (bck_valid_i         | ~monitor_en_i[0]) &
                        (ws_valid_i          | ~monitor_en_i[1]) &
                        (asynchronous_lock_i | ~monitor_en_i[2]);
    st_next.auto_sel  = auto_source_choice_i;
    st_next.ratio_ok  = ratio_valid_i;
    // two stages so a pin edge cannot reach the read mux half-settled
    st_next.gpio_meta = gpio_i;
    st_next.gpio_sync = st_reg.gpio_meta;
    st_next.coeff     = coeff_i;
    // source word built here from the freshly sampled flags, so the
    // whole next state comes out of this one process
    st_next.src = '0;
    st_next.src[SRC_VOL_LSB  +: CHANNELS] = st_next.vol_min;
    st_next.src[SRC_MUTE_LSB +: CHANNELS] = st_next.mute;
    st_next.src[SRC_RAMP_LSB +: CHANNELS] =
      st_next.ramp_up | st_next.ramp_dn;
    st_next.src[SRC_DOP_BIT]    = st_next.dop[0];
    st_next.src[SRC_CLKMON_BIT] = st_next.clkmon_ok;
    st_next.src[SRC_TDM_BIT]    = st_next.tdm_ok;
    st_next.src[SRC_SEL_LSB +: 2] = st_next.auto_sel;
    st_next.rvalid    = rd_i;
    if (rd_i) begin
      // reads see the snapshot of the previous cycle, one stable image
      case (addr_i)
        OFF_SRC_FLAGS:     st_next.rdata = st_reg.src[7:0];
        OFF_SRC_FLAGS + 8'h01: st_next.rdata = st_reg.src[15:8];
        OFF_SRC_FLAGS + 8'h02: st_next.rdata = st_reg.src[23:16];
        OFF_SRC_FLAGS + 8'h03: st_next.rdata = st_reg.src[31:24];
        OFF_SRC_LAST:      st_next.rdata = st_reg.src[39:32];
        OFF_RATIO: begin
          st_next.rdata = '0;
          st_next.rdata[RATIO_BIT] = st_reg.ratio_ok;
        end
        OFF_GPIO:      st_next.rdata = st_reg.gpio_sync;
        OFF_VOL_FLOOR: st_next.rdata = st_reg.vol_min;
        OFF_SIL_MUTE:  st_next.rdata = st_reg.mute;
        OFF_RAMP_UP:   st_next.rdata = st_reg.ramp_up;
        OFF_RAMP_DN:   st_next.rdata = st_reg.ramp_dn;
        OFF_IN_FORMAT: begin
          st_next.rdata = '0;
          st_next.rdata[FMT_SPDIF_BIT] = st_reg.spdif_ok;
          st_next.rdata[FMT_TDM_BIT]   = st_reg.tdm_ok;
          st_next.rdata[FMT_DOP_LSB +: DOP_W] = st_reg.dop;
          st_next.rdata[FMT_SEL_LSB +: 2] = st_reg.auto_sel;
        end
        OFF_COEFF:      st_next.rdata = st_reg.coeff[7:0];
        OFF_COEFF + 8'h01: st_next.rdata = st_reg.coeff[15:8];
        OFF_COEFF_LAST: st_next.rdata = st_reg.coeff[23:16];
        OFF_PAYLOAD:    st_next.rdata = mif.rd_data;
        // reserved and foreign addresses read as zero
        default:        st_next.rdata = RDATA_RST;
      endcase
    end
    // wr_i and wdata_i reach no state: every register is read-only
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o     = st_reg.rdata;
  assign rvalid_o    = st_reg.rvalid;
  assign src_flags_o = st_reg.src;

  // checks on the bank's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_vol_zero;
    (vol_level_i[7:0] == 8'h00) |=> src_flags_o[0];
  endproperty
  a_vol_zero: assert property (p_vol_zero)
    else $error("volume zero not flagged on channel 1");

  property p_vol_nonzero;
    (vol_level_i[63:56] != 8'h00) |=> !src_flags_o[7];
  endproperty
  a_vol_nonzero: assert property (p_vol_nonzero)
    else $error("volume flag set while channel 8 volume nonzero");

  property p_mute_byte;
    1'b1 |=> (src_flags_o[15:8] == $past(automute_active_i));
  endproperty
  a_mute_byte: assert property (p_mute_byte)
    else $error("automute byte does not follow channels");

  property p_ramp_byte;
    1'b1 |=> (src_flags_o[23:16] ==
              ($past(ramp_up_done_i) | $past(ramp_down_done_i)));
  endproperty
  a_ramp_byte: assert property (p_ramp_byte)
    else $error("full ramp byte wrong");

  property p_dop_bit;
    dop_valid_i[0] |=> src_flags_o[24];
  endproperty
  a_dop_bit: assert property (p_dop_bit)
    else $error("dop flag missing");

  property p_clkmon;
    (monitor_en_i[1] && !ws_valid_i) |=> !src_flags_o[25];
  endproperty
  a_clkmon: assert property (p_clkmon)
    else $error("clock monitor flag high with word select failing");

  property p_tdm_bit;
    1'b1 |=> (src_flags_o[29] == $past(tdm_data_valid_i));
  endproperty
  a_tdm_bit: assert property (p_tdm_bit)
    else $error("tdm flag wrong");

  property p_sel_rsvd;
    1'b1 |=> (src_flags_o[31:30] == $past(auto_source_choice_i)) &&
             (src_flags_o[39:32] == 8'h00) && (src_flags_o[28:26] == 3'h0);
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd)
    else $error("select field or reserved bits wrong");

  property p_ratio_read;
    (rd_i && addr_i == 8'hef) |=>
      rvalid_o && (rdata_o == {$past(ratio_valid_i, 2), 7'h00});
  endproperty
  a_ratio_read: assert property (p_ratio_read)
    else $error("ratio status read wrong");

  property p_ramp_up_read;
    (rd_i && addr_i == 8'hf3) |=> (rdata_o == $past(ramp_up_done_i, 2));
  endproperty
  a_ramp_up_read: assert property (p_ramp_up_read)
    else $error("ramp up status read wrong");

  property p_ramp_dn_read;
    (rd_i && addr_i == 8'hf4) |=> (rdata_o == $past(ramp_down_done_i, 2));
  endproperty
  a_ramp_dn_read: assert property (p_ramp_dn_read)
    else $error("ramp down status read wrong");

  property p_coeff_read;
    (rd_i && addr_i == 8'hf8) |=> (rdata_o == $past(coeff_i[23:16], 2));
  endproperty
  a_coeff_read: assert property (p_coeff_read)
    else $error("coefficient top byte read wrong");

  property p_payload_read;
    (rd_i && addr_i == 8'hfb) |=> (rdata_o == $past(mif.rd_data));
  endproperty
  a_payload_read: assert property (p_payload_read)
    else $error("payload read wrong");

  property p_wr_ignored;
    (wr_i && !rd_i) |=> !rvalid_o && $stable(rdata_o);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored)
    else $error("write disturbed the read port");

  property p_gpio_read;
    (rd_i && addr_i == 8'hf0) |=> (rdata_o == $past(gpio_i, 3));
  endproperty
  a_gpio_read: assert property (p_gpio_read)
    else $error("gpio readback wrong");

  property p_unmapped;
    (rd_i && addr_i == 8'hf9) |=> (rdata_o == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("reserved address read nonzero");

  property p_src_top_read;
    (rd_i && addr_i == 8'hee) |=> (rdata_o == 8'h00);
  endproperty
  a_src_top_read: assert property (p_src_top_read)
    else $error("reserved source byte read nonzero");

  property p_src_sel_read;
    (rd_i && addr_i == 8'hed) |=> (rdata_o == $past(src_flags_o[31:24]));
  endproperty
  a_src_sel_read: assert property (p_src_sel_read)
    else $error("source byte four read differs from the word");

  property p_vol_floor_read;
    (rd_i && addr_i == 8'hf1) |=> (rdata_o == $past(src_flags_o[7:0]));
  endproperty
  a_vol_floor_read: assert property (p_vol_floor_read)
    else $error("volume floor register differs from source byte");

  property p_mute_read;
    (rd_i && addr_i == 8'hf2) |=> (rdata_o == $past(automute_active_i, 2));
  endproperty
  a_mute_read: assert property (p_mute_read)
    else $error("silence mute register read wrong");

  property p_fmt_read;
    (rd_i && addr_i == 8'hf5) |=>
      (rdata_o == {$past(spdif_valid_i, 2), $past(tdm_data_valid_i, 2),
                   $past(dop_valid_i, 2), $past(auto_source_choice_i, 2)});
  endproperty
  a_fmt_read: assert property (p_fmt_read)
    else $error("input format status read wrong");

  property p_coeff_lo_read;
    (rd_i && addr_i == 8'hf6) |=> (rdata_o == $past(coeff_i[7:0], 2));
  endproperty
  a_coeff_lo_read: assert property (p_coeff_lo_read)
    else $error("coefficient low byte read wrong");

  property p_rvalid_pulse;
    rd_i |=> rvalid_o;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("read not answered one cycle later");

  property p_rvalid_idle;
    !rd_i |=> !rvalid_o;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle)
    else $error("answer strobe raised without a read");

  property p_rdata_hold;
    !rd_i |=> $stable(rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  // main scenarios
  c_src_read: cover property (rd_i && addr_i == 8'hea ##1 rdata_o != 8'h00);
  c_payload:  cover property (payload_we_i ##2 rd_i && addr_i == 8'hfb);
  c_gpio:     cover property (rd_i && addr_i == 8'hf0 ##1 rdata_o != 8'h00);
  c_clk_fail: cover property (monitor_en_i[1] && !ws_valid_i
                              ##1 !src_flags_o[25]);
  c_wr_seen:  cover property (wr_i && !rd_i ##1 !rvalid_o);
endmodule
`default_nettype wire

// ### dsrb_pkg.sv
// shared constants for the converter status readback bank
package dsrb_pkg;
  localparam int unsigned CHANNELS     = 8;            // audio channels
  localparam int unsigned ADDR_W       = 8;            // control port address
  localparam int unsigned DATA_W       = 8;            // control port data
  localparam int unsigned PAYLOAD_AW   = 5;            // payload byte select
  localparam int unsigned PAYLOAD_N    = 32;           // payload bytes held
  localparam int unsigned COEFF_W      = 24;           // coefficient width
  localparam int unsigned SRC_W        = 40;           // source word width
  localparam int unsigned DOP_W        = 4;            // dop valid flags

  // byte addresses of the readback registers
  localparam logic [7:0] OFF_SRC_FLAGS   = 8'hea;      // 40 bits, 0xea..0xee
  localparam logic [7:0] OFF_SRC_LAST    = 8'hee;
  localparam logic [7:0] OFF_RATIO       = 8'hef;
  localparam logic [7:0] OFF_GPIO        = 8'hf0;
  localparam logic [7:0] OFF_VOL_FLOOR   = 8'hf1;
  localparam logic [7:0] OFF_SIL_MUTE    = 8'hf2;
  localparam logic [7:0] OFF_RAMP_UP     = 8'hf3;
  localparam logic [7:0] OFF_RAMP_DN     = 8'hf4;
  localparam logic [7:0] OFF_IN_FORMAT   = 8'hf5;
  localparam logic [7:0] OFF_COEFF       = 8'hf6;      // 24 bits, 0xf6..0xf8
  localparam logic [7:0] OFF_COEFF_LAST  = 8'hf8;
  localparam logic [7:0] OFF_PAYLOAD     = 8'hfb;

  // field positions inside the source word
  localparam int unsigned SRC_VOL_LSB    = 0;
  localparam int unsigned SRC_MUTE_LSB   = 8;
  localparam int unsigned SRC_RAMP_LSB   = 16;
  localparam int unsigned SRC_DOP_BIT    = 24;
  localparam int unsigned SRC_CLKMON_BIT = 25;
  localparam int unsigned SRC_TDM_BIT    = 29;
  localparam int unsigned SRC_SEL_LSB    = 30;

  // field positions inside the input format and ratio status bytes
  localparam int unsigned FMT_SPDIF_BIT  = 7;
  localparam int unsigned FMT_TDM_BIT    = 6;
  localparam int unsigned FMT_DOP_LSB    = 2;
  localparam int unsigned FMT_SEL_LSB    = 0;
  localparam int unsigned RATIO_BIT      = 7;

  localparam logic [7:0] VOL_ZERO        = 8'h00;      // volume at minimum
  localparam logic [7:0] RDATA_RST       = 8'h00;      // read data at reset
endpackage

// ### dsrb_mem_if.sv
// payload memory port between the bank and its byte store
`timescale 1ns/1ps
`default_nettype none
interface dsrb_mem_if;
  import dsrb_pkg::*;
  logic                  wr_en;     // store one payload byte
  logic [PAYLOAD_AW-1:0] wr_addr;   // byte index written
  logic [7:0]            wr_data;   // byte written
  logic [PAYLOAD_AW-1:0] rd_addr;   // byte index read
  logic [7:0]            rd_data;   // registered read byte
  modport bank (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### dsrb_payload_mem.sv
// byte store for the received s/pdif payload, registered read
`timescale 1ns/1ps
`default_nettype none
module dsrb_payload_mem
  import dsrb_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  dsrb_mem_if.mem   port
);
  typedef struct packed {
    logic [PAYLOAD_N-1:0][7:0] bytes;  // payload image
    logic [7:0]                rd;     // read data flop
  } dsrb_mem_st_t;

  dsrb_mem_st_t st_reg;
  dsrb_mem_st_t st_next;

  // read first: a same-address collision returns the old byte
  always_comb begin
    st_next = st_reg;
    if (port.wr_en) begin
      st_next.bytes[port.wr_addr] = port.wr_data;
    end
    st_next.rd = st_reg.bytes[port.rd_addr];
  end

  // state register, cleared image after reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign port.rd_data = st_reg.rd;
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the converter status readback bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import dsrb_pkg::*;
();
  logic                  clk_i;            // 200 MHz core clock
  logic                  nrst_i;           // async reset, active low
  logic                  rd_i;             // read request
  logic                  wr_i;             // write request, must be ignored
  logic [ADDR_W-1:0]     addr_i;           // register byte address
  logic [DATA_W-1:0]     wdata_i;          // write data
  logic [DATA_W-1:0]     rdata_o;          // read answer
  logic                  rvalid_o;         // read answer strobe
  logic [CHANNELS*8-1:0] vol_level_i;      // per channel volume
  logic [CHANNELS-1:0]   automute_active_i;
  logic [CHANNELS-1:0]   ramp_up_done_i;
  logic [CHANNELS-1:0]   ramp_down_done_i;
  logic [CHANNELS-1:0]   gpio_i;           // pin levels
  logic [DOP_W-1:0]      dop_valid_i;
  logic                  spdif_valid_i;
  logic                  tdm_data_valid_i;
  logic                  bck_valid_i;
  logic                  ws_valid_i;
  logic                  asynchronous_lock_i;
  logic                  ratio_valid_i;
  logic [2:0]            monitor_en_i;     // monitor enables
  logic [1:0]            auto_source_choice_i;
  logic [COEFF_W-1:0]    coeff_i;
  logic                  payload_we_i;     // payload capture strobe
  logic [PAYLOAD_AW-1:0] payload_idx_i;
  logic [7:0]            payload_byte_i;
  logic [PAYLOAD_AW-1:0] payload_sel_i;    // host byte select
  logic [SRC_W-1:0]      src_flags_o;      // live source word
  int                    fails;            // mismatches seen
  int                    checks_done;      // comparisons made
  int                    sels [4] = '{0, 1, 17, 31};
  logic [7:0]            rsv  [5] = '{8'hf9, 8'hfa, 8'he9, 8'h00, 8'hfc};

  dsrb_status_bank i_dut (
    .clk_i, .nrst_i, .rd_i, .wr_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o,
    .vol_level_i, .automute_active_i, .ramp_up_done_i, .ramp_down_done_i,
    .dop_valid_i, .spdif_valid_i, .tdm_data_valid_i, .bck_valid_i,
    .ws_valid_i, .asynchronous_lock_i, .monitor_en_i, .auto_source_choice_i,
    .ratio_valid_i, .gpio_i, .coeff_i, .payload_we_i, .payload_idx_i,
    .payload_byte_i, .payload_sel_i, .src_flags_o
  );

  // free running clock, 5 ns period
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // verdict and end of run, reached from the main sequence or a hang
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // single comparison point, four-state exact
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected source word worked out from the bench's own stimulus
  function automatic logic [SRC_W-1:0] exp_src();
    logic [SRC_W-1:0] s;
    s = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      s[c] = (vol_level_i[8*c +: 8] === 8'h00);
    end
    s[15:8]  = automute_active_i;
    s[23:16] = ramp_up_done_i | ramp_down_done_i;
    s[24]    = dop_valid_i[0];
    // a disabled monitor never flags a failure
    s[25]    = (!monitor_en_i[0] || bck_valid_i) &&
               (!monitor_en_i[1] || ws_valid_i) &&
               (!monitor_en_i[2] || asynchronous_lock_i);
    s[29]    = tdm_data_valid_i;
    s[31:30] = auto_source_choice_i;
    return s;
  endfunction

  // one read: request held one edge, answer awaited under a bound
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    rd_i   = 1'b1;
    addr_i = a;
    @(negedge clk_i);
    rd_i = 1'b0;
    n    = 0;
    while (rvalid_o !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    if (rvalid_o !== 1'b1) begin
      fails++;
      $display("ERROR at %0t: no read answer", $time);
      report_and_stop();
    end
    d = rdata_o;
  endtask

  // read and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // write attempt with all ones, must leave no trace
  task automatic wr(input logic [7:0] a);
    @(negedge clk_i);
    wr_i    = 1'b1;
    addr_i  = a;
    wdata_i = 8'hff;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask

  // reset held eight cycles, outputs must sit at zero meanwhile
  task automatic do_reset();
    nrst_i = 1'b0;
    repeat (8) @(negedge clk_i);
    chk(rdata_o, 8'h00);
    chk(rvalid_o, 1'b0);
    chk(src_flags_o, '0);
    nrst_i = 1'b1;
  endtask

  // status pattern number i; covers zero and 0x01 volumes, monitor table
  task automatic apply(input int i);
    for (int c = 0; c < CHANNELS; c++) begin
      vol_level_i[8*c +: 8] = ((c + i) % 3 == 0) ? 8'h00 :
                              ((c % 2 == 1) ? 8'h01 : 8'hff);
    end
    automute_active_i    = 8'ha5 ^ {8{i[0]}};
    ramp_up_done_i       = 8'h0f << i;
    ramp_down_done_i     = 8'h81 >> i;
    dop_valid_i          = 4'h1 << i;
    spdif_valid_i        = i[0];
    tdm_data_valid_i     = i[1];
    bck_valid_i          = (i != 1);
    ws_valid_i           = (i != 1) && (i != 2);
    asynchronous_lock_i  = (i != 3);
    monitor_en_i         = (i == 0) ? 3'h0 : ((i == 2) ? 3'h1 : 3'h7);
    auto_source_choice_i = i[1:0];
    ratio_valid_i        = i[0];
    gpio_i               = 8'h3c ^ (8'h11 << i);
    coeff_i              = 24'ha5c3e1 + 24'(i) * 24'h010101;
  endtask

  // settle the status, then check the word and every readback byte except the payload
  task automatic check_all();
    logic [SRC_W-1:0] s;
    repeat (4) @(negedge clk_i);
    s = exp_src();
    chk(src_flags_o, s);
    for (int b = 0; b < 5; b++) begin
      rchk(OFF_SRC_FLAGS + 8'(b), s[8*b +: 8]);
    end
    rchk(OFF_VOL_FLOOR, s[7:0]);
    rchk(OFF_SIL_MUTE, s[15:8]);
    rchk(OFF_RAMP_UP, ramp_up_done_i);
    rchk(OFF_RAMP_DN, ramp_down_done_i);
    rchk(OFF_RATIO, {ratio_valid_i, 7'h00});
    rchk(OFF_GPIO, gpio_i);
    rchk(OFF_IN_FORMAT, {spdif_valid_i, tdm_data_valid_i, dop_valid_i,
                         auto_source_choice_i});
    for (int b = 0; b < 3; b++) begin
      rchk(OFF_COEFF + 8'(b), coeff_i[8*b +: 8]);
    end
  endtask

  // main sequence
  initial begin
    nrst_i = 1'b0;
    rd_i = 1'b0;
    wr_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    payload_we_i = 1'b0;
    payload_idx_i = 5'h00;
    payload_byte_i = 8'h00;
    payload_sel_i = 5'h00;
    fails = 0;
    checks_done = 0;
    apply(0);
    do_reset();
    rchk(OFF_PAYLOAD, 8'h00);
    // flags follow their inputs both ways, never sticky
    for (int i = 0; i < 4; i++) begin
      apply(i);
      check_all();
    end
    wr(OFF_GPIO);
    wr(OFF_SRC_FLAGS);
    wr(OFF_COEFF);
    check_all();
    for (int i = 0; i < 5; i++) begin
      rchk(rsv[i], 8'h00);
    end
    // fill the whole payload store back to back
    for (int i = 0; i < 32; i++) begin
      @(negedge clk_i);
      payload_we_i   = 1'b1;
      payload_idx_i  = 5'(i);
      payload_byte_i = 8'h5a ^ 8'(i * 7);
    end
    @(negedge clk_i);
    payload_we_i = 1'b0;
    // select first, then read, including both ends of the index
    for (int i = 0; i < 4; i++) begin
      payload_sel_i = 5'(sels[i]);
      repeat (2) @(negedge clk_i);
      rchk(OFF_PAYLOAD, 8'h5a ^ 8'(sels[i] * 7));
    end
    // second reset in mid run, then recovery
    @(negedge clk_i);
    do_reset();
    rchk(OFF_PAYLOAD, 8'h00);
    apply(1);
    check_all();
    report_and_stop();
  end
endmodule
`default_nettype wire
